// ==== latch_ctrl.sv ====
// set-reset latch control: axi4-lite registers, software pulses,
// periodic pulse source and gated true/inverted output pins
// assumes one 50 MHz clock; pin direction is set elsewhere by software
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module latch_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output var latch_ctrl_pkg::latch_pin_t true_output_pin,
	output var latch_ctrl_pkg::latch_pin_t inverted_output_pin
);
	latch_ctrl_pkg::ctrl_t ctrl_r; // stored control fields
	logic periodic_set_enable_r; // periodic source may set
	logic periodic_reset_enable_r; // periodic source may reset
	logic [2:0] set_cnt_r; // remaining clocks of software set
	logic [2:0] rst_cnt_r; // remaining clocks of software reset
	logic latch_q_r; // the latch itself, no reset value
	logic bvalid_r; // write response pending
	logic [1:0] bresp_r; // write response code
	logic rvalid_r; // read data pending
	logic [1:0] rresp_r; // read response code
	logic [31:0] rdata_r; // read data
	logic rd_ctrl_r; // pending read was the control register
	latch_ctrl_pkg::latch_pin_t tpin_r; // true pin flops
	latch_ctrl_pkg::latch_pin_t npin_r; // inverted pin flops
	logic wr_go; // write accepted this clock
	logic rd_go; // read accepted this clock
	logic ctrl_wr; // byte 0 of control register written
	logic per_wr; // byte 0 of periodic register written
	logic sw_set; // software set input
	logic sw_rst; // software reset input
	logic tick; // periodic pulse
	logic set_in; // combined set input
	logic rst_in; // combined reset input

	// address and data are taken together, one write at a time
	assign wr_go = awvalid && wvalid && !bvalid_r;
	assign awready = wr_go;
	assign wready = wr_go;
	assign ctrl_wr = wr_go && wstrb[0] &&
		(awaddr == latch_ctrl_pkg::CTRL_OFFSET);
	assign per_wr = wr_go && wstrb[0] &&
		(awaddr == latch_ctrl_pkg::PERIODIC_OFFSET);
	// one read at a time; next accepted once data is taken
	assign rd_go = arvalid && !rvalid_r;
	assign arready = rd_go;

	// control fields; pulse bits are not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= latch_ctrl_pkg::ctrl_t'(latch_ctrl_pkg::CTRL_RESET[7:2]);
		end else if (ctrl_wr) begin
			ctrl_r.en <= wdata[latch_ctrl_pkg::CTRL_EN_BIT];
			ctrl_r.div <= wdata[latch_ctrl_pkg::CTRL_DIV_LSB +: 3];
			ctrl_r.qen <= wdata[latch_ctrl_pkg::CTRL_QEN_BIT];
			ctrl_r.nqen <= wdata[latch_ctrl_pkg::CTRL_NQEN_BIT];
		end
	end

	// periodic source enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periodic_set_enable_r <= 1'b0;
			periodic_reset_enable_r <= 1'b0;
		end else if (per_wr) begin
			periodic_set_enable_r <= wdata[latch_ctrl_pkg::PER_SET_BIT];
			periodic_reset_enable_r <= wdata[latch_ctrl_pkg::PER_RST_BIT];
		end
	end

	// software set pulse: a one loads the instruction-cycle count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			set_cnt_r <= 3'h0;
		end else if (ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PSET_BIT]) begin
			set_cnt_r <= latch_ctrl_pkg::INSTR_CYCLES;
		end else if (set_cnt_r != 3'h0) begin
			set_cnt_r <= set_cnt_r - 3'h1;
		end
	end

	// software reset pulse, same shape; a zero written has no effect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt_r <= 3'h0;
		end else if (ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PRST_BIT]) begin
			rst_cnt_r <= latch_ctrl_pkg::INSTR_CYCLES;
		end else if (rst_cnt_r != 3'h0) begin
			rst_cnt_r <= rst_cnt_r - 3'h1;
		end
	end

	assign sw_set = (set_cnt_r != 3'h0);
	assign sw_rst = (rst_cnt_r != 3'h0);

	// periodic pulse source
	periodic_pulse #(
		.CNT_W(latch_ctrl_pkg::DIV_CNT_W)
	) u_periodic (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(ctrl_r.div),
		.tick(tick)
	);

	// gather set and reset sources
	assign set_in = sw_set || (tick && periodic_set_enable_r);
	assign rst_in = sw_rst || (tick && periodic_reset_enable_r);

	// the latch: no reset term, so its state is unknown until software
	// pulses it; reset dominates when both inputs are high
	always_ff @(posedge aclk) begin
		if (rst_in) begin
			latch_q_r <= 1'b0;
		end else if (set_in) begin
			latch_q_r <= 1'b1;
		end
	end

	// true pin: driven only with latch and its own enable on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tpin_r <= '{level: 1'b0, drive_n: 1'b1};
		end else if (ctrl_r.en && ctrl_r.qen) begin
			tpin_r <= '{level: latch_q_r, drive_n: 1'b0};
		end else begin
			tpin_r <= '{level: 1'b0, drive_n: 1'b1};
		end
	end

	// inverted pin: independent of the true pin's enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			npin_r <= '{level: 1'b0, drive_n: 1'b1};
		end else if (ctrl_r.en && ctrl_r.nqen) begin
			npin_r <= '{level: !latch_q_r, drive_n: 1'b0};
		end else begin
			npin_r <= '{level: 1'b0, drive_n: 1'b1};
		end
	end

	assign true_output_pin = tpin_r;
	assign inverted_output_pin = npin_r;

	// write response; unmapped addresses answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= latch_ctrl_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			if (awaddr == latch_ctrl_pkg::CTRL_OFFSET ||
				awaddr == latch_ctrl_pkg::PERIODIC_OFFSET ||
				awaddr == latch_ctrl_pkg::STATUS_OFFSET) begin
				bresp_r <= latch_ctrl_pkg::RESP_OKAY;
			end else begin
				bresp_r <= latch_ctrl_pkg::RESP_SLVERR;
			end
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	// read data; pulse bits always read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= latch_ctrl_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			rd_ctrl_r <= 1'b0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r <= latch_ctrl_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			rd_ctrl_r <= (araddr == latch_ctrl_pkg::CTRL_OFFSET);
			if (araddr == latch_ctrl_pkg::CTRL_OFFSET) begin
				rdata_r[7:2] <= ctrl_r;
			end else if (araddr == latch_ctrl_pkg::PERIODIC_OFFSET) begin
				rdata_r[latch_ctrl_pkg::PER_SET_BIT] <= periodic_set_enable_r;
				rdata_r[latch_ctrl_pkg::PER_RST_BIT] <=
					periodic_reset_enable_r;
			end else if (araddr == latch_ctrl_pkg::STATUS_OFFSET) begin
				rdata_r[latch_ctrl_pkg::STAT_Q_BIT] <= latch_q_r;
				rdata_r[latch_ctrl_pkg::STAT_NQ_BIT] <= !latch_q_r;
			end else begin
				rresp_r <= latch_ctrl_pkg::RESP_SLVERR; // unmapped
			end
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// true pin follows latch one clock later when enabled
	property p_true_pin;
		(ctrl_r.en && ctrl_r.qen) |=>
			(!tpin_r.drive_n && tpin_r.level == $past(latch_q_r));
	endproperty
	a_true_pin: assert property (p_true_pin)
		else $error("true pin not driven with latch state");

	// inverted pin carries the complement
	property p_inv_pin;
		(ctrl_r.en && ctrl_r.nqen) |=>
			(!npin_r.drive_n && npin_r.level == !$past(latch_q_r));
	endproperty
	a_inv_pin: assert property (p_inv_pin)
		else $error("inverted pin not driven with complement");

	// both pins may drive together with opposite levels
	property p_both_pins;
		(ctrl_r.en && ctrl_r.qen && ctrl_r.nqen) |=>
			(!tpin_r.drive_n && !npin_r.drive_n &&
			tpin_r.level != npin_r.level);
	endproperty
	a_both_pins: assert property (p_both_pins)
		else $error("pins not both driven");

	// disabled latch leaves both pins undriven whatever the pin enables
	property p_disabled;
		!ctrl_r.en |=> (tpin_r.drive_n && npin_r.drive_n);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("pin driven while latch disabled");

	// software pulse: high for exactly one instruction cycle; the
	// repeat counts must track the package's four-clock cycle count
	sequence s_set_high;
		sw_set [*4];
	endsequence
	// a set write, then four clocks with no fresh set write
	sequence s_set_quiet;
		(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PSET_BIT]) ##1
			(!(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PSET_BIT])) [*4];
	endsequence
	property p_set_pulse;
		(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PSET_BIT]) |=> s_set_high;
	endproperty
	a_set_pulse: assert property (p_set_pulse)
		else $error("pulse set not held one instruction cycle");

	// set input drops right after its cycle unless rewritten
	property p_set_end;
		s_set_quiet |=> !sw_set;
	endproperty
	a_set_end: assert property (p_set_end)
		else $error("pulse set held too long");

	sequence s_rst_high;
		sw_rst [*4];
	endsequence
	property p_rst_pulse;
		(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PRST_BIT]) |=> s_rst_high;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("pulse reset not held one instruction cycle");

	// a reset write, then four clocks with no fresh reset write
	sequence s_rst_quiet;
		(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PRST_BIT]) ##1
			(!(ctrl_wr && wdata[latch_ctrl_pkg::CTRL_PRST_BIT])) [*4];
	endsequence
	property p_rst_end;
		s_rst_quiet |=> !sw_rst;
	endproperty
	a_rst_end: assert property (p_rst_end)
		else $error("pulse reset held too long");

	// control reads never show the pulse bits
	property p_pulse_reads_zero;
		(rvalid_r && rd_ctrl_r) |-> (rdata_r[1:0] == 2'h0);
	endproperty
	a_pulse_reads_zero: assert property (p_pulse_reads_zero)
		else $error("pulse bit read back nonzero");

	// reset dominates
	property p_reset_wins;
		(set_in && rst_in) |=> !latch_q_r;
	endproperty
	a_reset_wins: assert property (p_reset_wins)
		else $error("latch not reset when both inputs high");

	// periodic pulse sets the latch only through its enable
	property p_periodic_set;
		(tick && periodic_set_enable_r && !rst_in) |=> latch_q_r;
	endproperty
	a_periodic_set: assert property (p_periodic_set)
		else $error("enabled periodic set missed");
endmodule // latch_ctrl
`default_nettype wire

// ==== latch_ctrl_pkg.sv ====
// shared constants and carrier types for the set-reset latch control block
// assumes a single 50 MHz clock and an axi4-lite register slave
`default_nettype none
package latch_ctrl_pkg;
	// register byte offsets
	localparam logic [3:0] CTRL_OFFSET = 4'h0; // latch_control_zero
	localparam logic [3:0] PERIODIC_OFFSET = 4'h4; // periodic set/reset enables
	localparam logic [3:0] STATUS_OFFSET = 4'h8; // latch state, read only
	// latch_control_zero field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_DIV_LSB = 4;
	localparam int CTRL_QEN_BIT = 3;
	localparam int CTRL_NQEN_BIT = 2;
	localparam int CTRL_PSET_BIT = 1;
	localparam int CTRL_PRST_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// periodic enable register field positions
	localparam int PER_SET_BIT = 1;
	localparam int PER_RST_BIT = 0;
	// status register field positions
	localparam int STAT_Q_BIT = 0;
	localparam int STAT_NQ_BIT = 1;
	// one instruction cycle spans four oscillator cycles
	localparam int OSC_PER_INSTR = 4;
	localparam logic [2:0] INSTR_CYCLES = 3'(OSC_PER_INSTR);
	// periodic divider: shortest period and counter width for the longest
	localparam int DIV_BASE = 4;
	localparam int DIV_CNT_W = 9;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// software view of latch_control_zero
	typedef struct packed {
		logic en; // latch_enable
		logic [2:0] div; // pulse_divider_select
		logic qen; // true_output_enable
		logic nqen; // inverted_output_enable
	} ctrl_t;

	// one latch output pin: level plus active-low drive enable
	typedef struct packed {
		logic level;
		logic drive_n;
	} latch_pin_t;
endpackage
`default_nettype wire

// ==== periodic_pulse.sv ====
// free-running divider making a one-cycle pulse every 4..512 clocks
// assumes sel comes from a register on the same clock
`default_nettype none
module periodic_pulse #(
	parameter int CNT_W = latch_ctrl_pkg::DIV_CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [CNT_W-1:0] cnt_r; // free-running count
	logic [CNT_W-1:0] last; // wrap value for the chosen period
	logic tick_r; // registered pulse

	// period is base shifted by the select code; wrap at period minus one
	always_comb begin
		last = CNT_W'((latch_ctrl_pkg::DIV_BASE << sel) - 1);
	end

	// counter wraps at the selected value; >= covers a shrinking select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (cnt_r >= last) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// pulse one clock wide at each wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= (cnt_r >= last);
		end
	end

	assign tick = tick_r;

	// helper: clocks since last pulse and whether sel held meanwhile
	logic [CNT_W:0] gap_r;
	logic seen_r;
	logic held_r;
	logic [2:0] sel_q_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_r <= '0;
			seen_r <= 1'b0;
			held_r <= 1'b0;
			sel_q_r <= 3'h0;
		end else begin
			sel_q_r <= sel;
			if (tick_r) begin
				gap_r <= '0;
				seen_r <= 1'b1;
				held_r <= 1'b1;
			end else begin
				gap_r <= gap_r + 1'b1;
				held_r <= held_r && (sel == sel_q_r);
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// pulses are exactly the selected period apart while sel is steady
	property p_tick_period;
		(tick_r && seen_r && held_r && sel == sel_q_r) |->
			(32'(gap_r) == (latch_ctrl_pkg::DIV_BASE << sel) - 1);
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("periodic pulse spacing wrong");

	// pulse is one clock wide
	property p_tick_width;
		tick_r |=> !tick_r;
	endproperty
	a_tick_width: assert property (p_tick_width)
		else $error("periodic pulse wider than one clock");
endmodule // periodic_pulse
`default_nettype wire

// ==== tb_set_reset_latch_control.sv ====
// self-checking bench for the set-reset latch control block
// assumes latch_ctrl_pkg and latch_ctrl are compiled before this file
`default_nettype none
module tb_set_reset_latch_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] CTRL = latch_ctrl_pkg::CTRL_OFFSET;
	localparam logic [3:0] PER = latch_ctrl_pkg::PERIODIC_OFFSET;
	localparam logic [3:0] STAT = latch_ctrl_pkg::STATUS_OFFSET;
	logic aclk, aresetn; // clock and sync reset
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	latch_ctrl_pkg::latch_pin_t tpin, ipin; // true and inverted pins
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0; // free cycle count for period measurement
	logic [31:0] rv; // last read data
	logic [1:0] rr; // last read response
	int t1, t2;

	latch_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .true_output_pin(tpin), .inverted_output_pin(ipin));

	// 50 mhz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// cycle counter, only used to time pin edges
	always @(posedge aclk) cyc <= cyc + 1;

	// print counts and verdict, then stop
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one bounded wait step at the falling edge
	task automatic step(inout int n);
		n++;
		if (n > 2000) begin
			err_count++;
			$display("CHECK FAILED %0t wait timed out", $time);
			give_verdict();
		end
		@(negedge aclk);
	endtask

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// idle cycles, ending mid-cycle so outputs are settled
	task automatic idle(input int n);
		repeat (n) @(negedge aclk);
	endtask

	// sync reset held 20 cycles
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// axi4-lite write of one byte-0 value; address and data offered together
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int n = 0;
		logic [1:0] resp;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge aclk);
		while (awready !== 1'b1 || wready !== 1'b1) step(n);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge aclk);
		while (bvalid !== 1'b1) step(n);
		resp = bresp; // value held up to the taking edge
		@(posedge aclk);
		bready <= 1'b0;
		chk({30'h0, resp}, {30'h0, latch_ctrl_pkg::RESP_OKAY}, "bresp");
	endtask

	// axi4-lite read into rv and rr
	task automatic rd(input logic [3:0] a);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		while (arready !== 1'b1) step(n);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		while (rvalid !== 1'b1) step(n);
		rv = rdata;
		rr = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// read and compare data plus okay response
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp, "read data");
		chk({30'h0, rr}, {30'h0, latch_ctrl_pkg::RESP_OKAY}, "rresp");
	endtask

	// wait for the true pin level, bounded
	task automatic wait_lvl(input logic v);
		int n = 0;
		@(negedge aclk);
		while (tpin.level !== v) step(n);
	endtask

	// time three periodic set events, keep the last gap; the write
	// latency and reset pulse can swallow a tick, so allow a whole
	// number of periods with some slack
	task automatic per_chk(input logic [2:0] c);
		int p;
		p = latch_ctrl_pkg::DIV_BASE << c;
		t2 = 0;
		for (int j = 0; j < 3; j++) begin
			t1 = t2;
			wr(CTRL, {1'b1, c, 4'b1001});
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			t2 = cyc;
		end
		num_checks++;
		if ((t2 - t1) % p != 0 || t2 - t1 > p + 16) begin
			err_count++;
			$display("CHECK FAILED %0t gap %0d code %0d", $time, t2 - t1, c);
		end
	endtask

	// main sequence
	initial begin
		aresetn = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wstrb = 4'h0;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		@(posedge aclk);
		do_reset();
		idle(1);
		// pins released and registers cleared after reset
		chk({30'h0, tpin.drive_n, ipin.drive_n}, 32'h3, "pins idle");
		rchk(CTRL, 32'h0);
		rchk(PER, 32'h0);
		rd(4'hc);
		chk({30'h0, rr}, {30'h0, latch_ctrl_pkg::RESP_SLVERR}, "unmapped");
		// software pulses; latch defined before any pin is enabled
		wr(CTRL, 8'h02);
		idle(8);
		rchk(STAT, 32'h1);
		rchk(CTRL, 32'h0);
		wr(CTRL, 8'h01);
		idle(8);
		rchk(STAT, 32'h2);
		wr(CTRL, 8'h02);
		idle(8);
		wr(CTRL, 8'h03);
		idle(8);
		rchk(STAT, 32'h2);
		wr(CTRL, 8'h02);
		idle(8);
		// every enable combination with the latch set
		for (int i = 0; i < 8; i++) begin
			logic [2:0] k;
			k = 3'(i);
			wr(CTRL, {k[2], 3'h0, k[1], k[0], 2'h0});
			idle(8);
			chk({31'h0, tpin.drive_n}, {31'h0, ~(k[2] & k[1])}, "q drive");
			chk({31'h0, ipin.drive_n}, {31'h0, ~(k[2] & k[0])}, "nq drive");
			if (k[2] & k[1]) chk({31'h0, tpin.level}, 32'h1, "q level");
			if (k[2] & k[0]) chk({31'h0, ipin.level}, 32'h0, "nq level");
		end
		// both pins on, then pulse reset flips them
		wr(CTRL, 8'h8d);
		idle(8);
		chk({30'h0, tpin.level, ipin.level}, 32'h1, "both levels");
		rchk(CTRL, 32'h8c);
		// latch state survives a reset
		wr(CTRL, 8'h02);
		idle(8);
		do_reset();
		idle(1);
		rchk(STAT, 32'h1);
		// periodic set source, every divider code
		wr(PER, 8'h02);
		for (int c = 0; c < 8; c++) per_chk(3'(c));
		// periodic source gated off, then resetting only
		wr(PER, 8'h00);
		wr(CTRL, 8'h02);
		idle(600);
		rchk(STAT, 32'h1);
		wr(PER, 8'h01);
		idle(600);
		rchk(STAT, 32'h2);
		give_verdict();
	end
endmodule // tb_set_reset_latch_control
`default_nettype wire
